// >>> rtl/hpd_cfg.sv
// Functional notes
// R1 - a mask bit of one disables its downstream port, zero leaves it available
// R2 - mask bits 7..1 map to ports 7..1; bit 0 reserved, always zero
// R3 - with renumbering off, masked ports stay disabled and never enumerable
// R4 - any port set may be off; report enabled count and renumber the rest
// R5 - internal default option takes disabled ports from the two strap pin sets
// R6 - each 8-bit maximum-current field counts upstream current in 2 mA units
// R7 - report self-powered current when self-powered, bus-powered when bus-powered
// R8 - software folds embedded peripheral current in when compound and it reports zero
// R9 - software keeps self-powered current at or under the 100 mA equivalent
// R10 - renumber enable zero is standard mode, one is re-map mode
// R11 - compound bit set to one declares the hub part of a compound device
// R12 - bus-powered mask applies when bus-powered, self-powered mask when self-powered
module hpd_cfg
    import hpd_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic self_powered,
    input wire logic [7:1] port_off_strap_plus,
    input wire logic [7:1] port_off_strap_minus,
    output logic [7:1] port_enable,
    output logic [3:0] reported_port_count,
    output logic [7:0] reported_max_current,
    output logic [20:0] logical_port_map,
    output logic remap_mode,
    output logic compound_device
);
    logic [7:0] off_self_q, off_self_d;
    logic [7:0] off_bus_q, off_bus_d;
    logic [7:0] cur_self_q, cur_self_d;
    logic [7:0] cur_bus_q, cur_bus_d;
    logic [2:0] ctrl_q, ctrl_d;
    hpd_state_e state_q, state_d;
    logic [7:0] addr_q, addr_d;
    logic wr_q, wr_d;
    logic [31:0] rdata_q, rdata_d;

    logic self_pwr_s;
    logic [7:1] strap_p_s, strap_m_s;

    hpd_sync #(.W(1)) u_sync_pwr (
        .hclk(hclk),
        .hresetn(hresetn),
        .d(self_powered),
        .q(self_pwr_s)
    );
    hpd_sync #(.W(7)) u_sync_strap_p (
        .hclk(hclk),
        .hresetn(hresetn),
        .d(port_off_strap_plus),
        .q(strap_p_s)
    );
    hpd_sync #(.W(7)) u_sync_strap_m (
        .hclk(hclk),
        .hresetn(hresetn),
        .d(port_off_strap_minus),
        .q(strap_m_s)
    );

    // effective disable mask
    logic [7:0] active_mask;
    logic [3:0] count_w;
    logic [20:0] map_w;
    always_comb begin
        if (ctrl_q[HPD_CTRL_USE_STRAP_BIT]) begin
            // either strap of a pair disables its port
            active_mask = {strap_p_s | strap_m_s, 1'b0}; // [R5]
        end else if (self_pwr_s) begin
            active_mask = off_self_q & HPD_MASK_VALID; // [R12] [R2]
        end else begin
            active_mask = off_bus_q & HPD_MASK_VALID; // [R12] [R2]
        end
    end

    hpd_renum u_renum (
        .off_mask(active_mask),
        .port_count(count_w),
        .phys_of_logical(map_w)
    );

    // output stage
    logic [7:1] port_enable_q, port_enable_d;
    logic [3:0] count_q, count_d;
    logic [7:0] cur_out_q, cur_out_d;
    logic [20:0] map_q, map_d;
    logic remap_q, remap_d;
    logic compound_q, compound_d;

    always_comb begin
        port_enable_d = ~active_mask[7:1]; // [R1] [R3]
        // numbering is packed here in both modes; the re-map bit does not change count or map
        count_d = count_w; // [R4] [R10]
        map_d = map_w; // [R4]
        // passed on in 2 mA counts, unscaled; the host side does the scaling
        if (self_pwr_s) begin
            cur_out_d = cur_self_q; // [R6] [R7]
        end else begin
            cur_out_d = cur_bus_q; // [R6] [R7]
        end
        remap_d = ctrl_q[HPD_CTRL_REMAP_BIT]; // [R10]
        compound_d = ctrl_q[HPD_CTRL_COMPOUND_BIT]; // [R11]
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_enable_q <= '0;
            count_q <= 4'h0;
            cur_out_q <= 8'h00;
            map_q <= '0;
            remap_q <= 1'b0;
            compound_q <= 1'b0;
        end else begin
            port_enable_q <= port_enable_d;
            count_q <= count_d;
            cur_out_q <= cur_out_d;
            map_q <= map_d;
            remap_q <= remap_d;
            compound_q <= compound_d;
        end
    end
    assign port_enable = port_enable_q;
    assign reported_port_count = count_q;
    assign reported_max_current = cur_out_q;
    assign logical_port_map = map_q;
    assign remap_mode = remap_q;
    assign compound_device = compound_q;

    // ahb-lite slave, zero wait states
    // one register per word: byte address is four times the register index
    logic req_take;
    logic req_read;
    logic req_write;
    logic addr_in_range;
    assign req_take = hsel & hready & htrans[1];
    assign req_read = req_take & ~hwrite;
    // upper address bits must be clear, so the registers do not alias upward
    assign addr_in_range = (haddr[31:10] == 22'h0);
    assign req_write = req_take & hwrite & addr_in_range;

    // bus phase: index and direction of the transfer now in its data phase
    // hsize is not decoded: transfers of any size reach these registers as whole words
    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        wr_d = 1'b0;
        if (req_take) begin
            state_d = HPD_DATA;
            addr_d = haddr[9:2];
            // out-of-window writes are dropped here rather than in every register
            wr_d = req_write;
        end else if (hready) begin
            state_d = HPD_IDLE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= HPD_IDLE;
            addr_q <= 8'h00;
            wr_q <= 1'b0;
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
            wr_q <= wr_d;
        end
    end

    // write strobes of the data phase, one per writable register; status and port map words have none
    logic wr_data_phase;
    logic we_off_self, we_off_bus, we_cur_self, we_cur_bus, we_ctrl;

    always_comb begin
        wr_data_phase = wr_q && (state_q == HPD_DATA);
        we_off_self = 1'b0;
        we_off_bus = 1'b0;
        we_cur_self = 1'b0;
        we_cur_bus = 1'b0;
        we_ctrl = 1'b0;
        if (wr_data_phase) begin
            case (addr_q)
                HPD_OFF_PORT_OFF_SELF: we_off_self = 1'b1;
                HPD_OFF_PORT_OFF_BUS: we_off_bus = 1'b1;
                HPD_OFF_MAX_CUR_SELF: we_cur_self = 1'b1;
                HPD_OFF_MAX_CUR_BUS: we_cur_bus = 1'b1;
                HPD_OFF_MODE_CTRL: we_ctrl = 1'b1;
                default: ;
            endcase
        end
    end

    // port disable masks
    always_comb begin
        off_self_d = off_self_q;
        off_bus_d = off_bus_q;
        if (we_off_self) begin
            // reserved bit 0 never stores a one
            off_self_d = hwdata[7:0] & HPD_MASK_VALID; // [R2]
        end
        if (we_off_bus) begin
            off_bus_d = hwdata[7:0] & HPD_MASK_VALID; // [R2]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            off_self_q <= HPD_RST_PORT_OFF;
            off_bus_q <= HPD_RST_PORT_OFF;
        end else begin
            off_self_q <= off_self_d;
            off_bus_q <= off_bus_d;
        end
    end

    // maximum current values, kept as written; their range is software's concern
    always_comb begin
        cur_self_d = cur_self_q;
        cur_bus_d = cur_bus_q;
        if (we_cur_self) begin
            cur_self_d = hwdata[7:0];
        end
        if (we_cur_bus) begin
            cur_bus_d = hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_self_q <= HPD_RST_MAX_CUR;
            cur_bus_q <= HPD_RST_MAX_CUR;
        end else begin
            cur_self_q <= cur_self_d;
            cur_bus_q <= cur_bus_d;
        end
    end

    // mode control: renumber enable, compound flag and strap source
    always_comb begin
        ctrl_d = ctrl_q;
        if (we_ctrl) begin
            ctrl_d = hwdata[2:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= 3'h0;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // read-only words, assembled apart so the read mux stays flat
    logic [31:0] status_word;
    logic [31:0] map_lo_word;
    logic [31:0] map_hi_word;
    assign status_word = {19'h0, self_pwr_s, count_q, active_mask};
    assign map_lo_word = {20'h0, map_q[11:0]};
    assign map_hi_word = {23'h0, map_q[20:12]};

    // read data; a read right after a write sees the value being written
    always_comb begin
        rdata_d = rdata_q;
        if (req_read) begin
            rdata_d = 32'h0;
            if (addr_in_range) begin
                case (haddr[9:2])
                    HPD_OFF_PORT_OFF_SELF: rdata_d = {24'h0, off_self_d};
                    HPD_OFF_PORT_OFF_BUS: rdata_d = {24'h0, off_bus_d};
                    HPD_OFF_MAX_CUR_SELF: rdata_d = {24'h0, cur_self_d};
                    HPD_OFF_MAX_CUR_BUS: rdata_d = {24'h0, cur_bus_d};
                    HPD_OFF_MODE_CTRL: rdata_d = {29'h0, ctrl_d};
                    HPD_OFF_STATUS: rdata_d = status_word;
                    HPD_OFF_PORT_MAP_LO: rdata_d = map_lo_word;
                    HPD_OFF_PORT_MAP_HI: rdata_d = map_hi_word;
                    default: rdata_d = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign hrdata = rdata_q;
    // every access completes in its first data phase, so ready never drops
    assign hreadyout = 1'b1;
    // unmapped accesses read zero instead of raising an error response
    assign hresp = 1'b0;
endmodule

// >>> pkg/hpd_pkg.sv
package hpd_pkg;
    localparam logic [7:0] HPD_OFF_PORT_OFF_SELF = 8'h0a;
    localparam logic [7:0] HPD_OFF_PORT_OFF_BUS = 8'h0b;
    localparam logic [7:0] HPD_OFF_MAX_CUR_SELF = 8'h0c;
    localparam logic [7:0] HPD_OFF_MAX_CUR_BUS = 8'h0d;
    localparam logic [7:0] HPD_OFF_MODE_CTRL = 8'h20;
    localparam logic [7:0] HPD_OFF_STATUS = 8'h24;
    localparam logic [7:0] HPD_OFF_PORT_MAP_LO = 8'h28;
    localparam logic [7:0] HPD_OFF_PORT_MAP_HI = 8'h2c;
    localparam int HPD_NPORT = 7;
    localparam logic [7:0] HPD_RST_PORT_OFF = 8'h00;
    localparam logic [7:0] HPD_RST_MAX_CUR = 8'h32;
    localparam logic [7:0] HPD_MASK_VALID = 8'hfe;
    localparam int HPD_CTRL_REMAP_BIT = 0;
    localparam int HPD_CTRL_COMPOUND_BIT = 1;
    localparam int HPD_CTRL_USE_STRAP_BIT = 2;
    localparam int HPD_CURRENT_STEP_MA = 2;
    localparam logic [7:0] HPD_MAX_SELF_LIMIT = 8'h32;
    typedef enum logic [1:0] {
        HPD_IDLE = 2'b01,
        HPD_DATA = 2'b10
    } hpd_state_e;
endpackage

// >>> rtl/hpd_sync.sv
module hpd_sync
    import hpd_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end
    assign q = sync_q;
endmodule

// >>> rtl/hpd_renum.sv
module hpd_renum
    import hpd_pkg::*;
(
    input wire logic [7:0] off_mask,
    output logic [3:0] port_count,
    output logic [20:0] phys_of_logical
);
    // packs enabled physical ports into logical slots 1..count, 3 bits per slot
    always_comb begin
        logic [3:0] n;
        n = 4'h0;
        phys_of_logical = '0;
        for (int p = 1; p <= HPD_NPORT; p++) begin
            if (!off_mask[p]) begin
                phys_of_logical[3*n +: 3] = 3'(p);
                n = n + 4'h1;
            end
        end
        port_count = n;
    end
endmodule

// >>> test/hpd_cfg_sva.sv
module hpd_cfg_chk
    import hpd_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [7:1] port_enable,
    input wire logic [3:0] reported_port_count,
    input wire logic [20:0] logical_port_map,
    input wire logic remap_mode,
    input wire logic compound_device
);
    wire logic wr_req = hsel & hready & htrans[1] & hwrite;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // judge the count and map only once the enables have settled
    sequence quiet_s;
        $stable(port_enable) [*3];
    endsequence
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    ready_high_a: assert property (hreadyout)
        else $error("wait state inserted");
    count_match_a: assert property (quiet_s |-> reported_port_count == $countones(port_enable))
        else $error("count differs from enabled ports");
    count_range_a: assert property (reported_port_count <= 4'h7)
        else $error("count above port total");
    map_tail_a: assert property (quiet_s |-> (logical_port_map >> (3 * reported_port_count)) == 21'h0)
        else $error("map slot beyond count used");
    map_head_a: assert property (quiet_s ##0 (reported_port_count != 4'h0) |-> port_enable[logical_port_map[2:0]])
        else $error("first logical port is a disabled one");
    remap_cause_a: assert property ($changed(remap_mode) |-> $past(wr_req, 3))
        else $error("renumber mode moved without a write");
    compound_cause_a: assert property ($changed(compound_device) |-> $past(wr_req, 3))
        else $error("compound flag moved without a write");
    upper_zero_a: assert property (hrdata[31:13] == 19'h0)
        else $error("upper read bits not zero");
endmodule
bind hpd_cfg hpd_cfg_chk chk_u (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata,
    .hreadyout, .hresp, .port_enable, .reported_port_count, .logical_port_map, .remap_mode,
    .compound_device);

// >>> test/hpd_host_model.sv
module hpd_host_model (
    input wire logic hclk,
    input wire logic [7:0] reported_max_current,
    output logic [8:0] draw_ma
);
    timeunit 1ns;
    timeprecision 1ps;
    // host budgets upstream current from the descriptor value at 2 mA a count
    always_ff @(posedge hclk) draw_ma <= {reported_max_current, 1'b0};
endmodule

// >>> test/tb_hub_port_disable_power_cfg.sv
module tb_hub_port_disable_power_cfg
    import hpd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 0, hresetn = 0, hwrite = 0, self_powered = 1;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd_v;
    logic hreadyout, hresp, remap_mode, compound_device;
    logic [7:1] port_off_strap_plus = 0, port_off_strap_minus = 0, port_enable;
    logic [3:0] reported_port_count;
    logic [7:0] reported_max_current;
    logic [20:0] logical_port_map;
    logic [8:0] draw_ma;
    int mismatches = 0, comparisons = 0, cyc = 0;
    hpd_cfg dut_u (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .self_powered, .port_off_strap_plus,
        .port_off_strap_minus, .port_enable, .reported_port_count, .reported_max_current,
        .logical_port_map, .remap_mode, .compound_device);
    hpd_host_model host_u (.hclk, .reported_max_current, .draw_ma);
    initial forever #2 hclk = ~hclk;
    // printed offsets 0x0a..0x0d are not word multiples, so all offsets are word indices
    function automatic logic [31:0] ra(input logic [7:0] i);
        return {22'h0, i, 2'b00};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= 1'b1;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic rd(input logic [31:0] a);
        haddr <= a;
        hwrite <= 1'b0;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_v = hrdata;
    endtask
    task t_reset;
        rd(ra(HPD_OFF_MAX_CUR_SELF));
        chk(rd_v, 32'h32);
        chk(reported_max_current, HPD_RST_MAX_CUR);
        chk(draw_ma, 9'd100);
        wr(ra(HPD_OFF_MAX_CUR_SELF), {24'h0, HPD_MAX_SELF_LIMIT});
    endtask
    task t_self_mask;
        wr(ra(HPD_OFF_PORT_OFF_SELF), 32'hff);
        rd(ra(HPD_OFF_PORT_OFF_SELF));
        chk(rd_v, 32'hfe);
        wr(ra(HPD_OFF_PORT_OFF_SELF), 32'h54);
        repeat (2) @(posedge hclk);
        chk(port_enable, 7'h55);
        chk(reported_port_count, 4'h4);
        chk(logical_port_map, 21'h000f59);
    endtask
    task t_bus;
        wr(ra(HPD_OFF_PORT_OFF_BUS), 32'h02);
        wr(ra(HPD_OFF_MAX_CUR_BUS), 32'h10);
        self_powered <= 1'b0;
        repeat (5) @(posedge hclk);
        chk(port_enable, 7'h7e);
        chk(reported_max_current, 8'h10);
        chk(draw_ma, 9'd32);
        self_powered <= 1'b1;
        repeat (4) @(posedge hclk);
        chk(port_enable, 7'h55);
    endtask
    task t_strap;
        port_off_strap_plus <= 7'h01;
        port_off_strap_minus <= 7'h40;
        wr(ra(HPD_OFF_MODE_CTRL), 32'h7);
        repeat (4) @(posedge hclk);
        chk(port_enable, 7'h3e);
        chk(reported_port_count, 4'h5);
        chk(logical_port_map, 21'h006b1a);
        chk(remap_mode, 1'b1);
        chk(compound_device, 1'b1);
        rd(ra(HPD_OFF_STATUS));
        chk(rd_v, 32'h1582);
        rd(ra(HPD_OFF_PORT_MAP_LO));
        chk(rd_v, 32'hb1a);
        rd(ra(HPD_OFF_PORT_MAP_HI));
        chk(rd_v, 32'h6);
        // compound hub, embedded peripheral reports 0 mA: its 50 mA is folded in
        wr(ra(HPD_OFF_MAX_CUR_SELF), 32'h28);
        repeat (3) @(posedge hclk);
        chk(reported_max_current, 8'h28);
        chk(draw_ma, 9'd80);
        rd(32'h40);
        chk(rd_v, 32'h0);
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 2000) begin
            mismatches++;
            give_verdict;
        end
    end
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset;
        t_self_mask;
        t_bus;
        t_strap;
        give_verdict;
    end
endmodule
